/* File: include/acr_defines.vh */
// Constants for the serial port clock role and dynamic channel configuration bank.
// Assumes the includer uses the register port of acr_cfg_top.
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

// ****************************************
// Register addresses
// ****************************************
`define ACR_ADDR_PAGE      8'h00
`define ACR_ADDR_CLK_ROLE  8'h0D
`define ACR_ADDR_ADC_CH    8'h0E
`define ACR_ADDR_DAC_CH    8'h0F
`define ACR_BANK_PAGE      8'h00

// ****************************************
// Reset values and writable bits
// ****************************************
`define ACR_RESET_VALUE    8'h00
`define ACR_CLK_ROLE_WMASK 8'hC6
`define ACR_CHAN_WMASK     8'hF8

// ****************************************
// Field positions
// ****************************************
`define ACR_PRI_OVERRIDE_BIT 7
`define ACR_SEC_OVERRIDE_BIT 6
`define ACR_PRI_INT_FS_BIT   2
`define ACR_SEC_INT_FS_BIT   1
`define ACR_FORCE_CUSTOM_BIT 7
`define ACR_CUSTOM_MASK_HI   6
`define ACR_CUSTOM_MASK_LO   3

`endif

/* File: verilog/acr_port_role.v */
// Clock role decoder for one audio serial port, registered outputs.
// Assumes role select and configuration bits come from logic on clock_i.
`timescale 1ns/100ps

module acr_port_role
(
   input  wire clock_i,
   input  wire rst_i,
   input  wire override_i,
   input  wire role_select_i,
   input  wire internal_fsync_i,
   output reg  bclk_drive_o,
   output reg  fsync_drive_o,
   output reg  autodetect_en_o,
   output reg  fsync_internal_o
);

   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         bclk_drive_o     <= 1'b0;
         fsync_drive_o    <= 1'b0;
         autodetect_en_o  <= 1'b1;
         fsync_internal_o <= 1'b0;
      end
      else
      begin
         // Bit clock always follows the select, overridden or not
         bclk_drive_o     <= role_select_i;
         // Override splits the directions: frame sync opposes bit clock
         fsync_drive_o    <= override_i ? ~role_select_i : role_select_i;
         // Ratio inference cannot work once directions are split
         autodetect_en_o  <= ~override_i;
         fsync_internal_o <= role_select_i & internal_fsync_i;
      end
   end

endmodule // acr_port_role

/* File: verilog/acr_cfg_top.v */
// Paged configuration bank: serial port clock roles and dynamic channel masks.
// Assumes the register port is driven by logic on clock_i (no synchronisers).
// Assumes role and max-channel selects come from registers on clock_i.
//
// Operation
// - With the primary override clear, the primary port role follows only its role select.
// - With primary override set and select 0, primary bit clock is input, frame sync output.
// - With primary override set and select 1, primary bit clock is output, frame sync input.
// - While the primary override is set, primary clock auto-detection is disabled.
// - With the secondary override clear, the secondary role follows only its role select.
// - With secondary override set and select 0, secondary bit clock in, frame sync out.
// - Secondary override set, select 1: bit clock out, frame sync in, auto-detect off.
// - Controller-mode primary port uses internal frame sync if bit 2 is 1, else external.
// - Controller-mode secondary port uses internal frame sync if bit 1 is 1, else external.
// - Dynamic ADC channels come from the ADC max-channel select, or the custom mask if forced.
// - ADC custom mask bits 6-3 enable channels 4 down to 1, one bit each.
// - Dynamic DAC channels come from the DAC max-channel select, or the custom mask if forced.
// - DAC custom mask bits 6-3 enable channels 4 down to 1, one bit each.
`timescale 1ns/100ps
`include "acr_defines.vh"

module acr_cfg_top
(
   input  wire       clock_i,
   input  wire       rst_i,
   input  wire [7:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   input  wire       reg_write_i,
   input  wire       reg_read_i,
   output reg  [7:0] reg_rdata_o,
   output reg  [7:0] page_o,
   input  wire       primary_role_select_i,
   input  wire       secondary_role_select_i,
   input  wire [3:0] adc_max_channel_select_i,
   input  wire [3:0] dac_max_channel_select_i,
   output wire       primary_bclk_drive_o,
   output wire       primary_fsync_drive_o,
   output wire       primary_autodetect_en_o,
   output wire       primary_fsync_internal_o,
   output wire       secondary_bclk_drive_o,
   output wire       secondary_fsync_drive_o,
   output wire       secondary_autodetect_en_o,
   output wire       secondary_fsync_internal_o,
   output reg  [3:0] adc_channel_enable_o,
   output reg  [3:0] dac_channel_enable_o
);

   // ****************************************
   // Register storage
   // ****************************************
   reg  [7:0] serial_port_clock_role_cfg;
   reg  [7:0] adc_dynamic_channel_cfg;
   reg  [7:0] dac_dynamic_channel_cfg;
   reg  [7:0] next_rdata;
   wire       bank_sel;
   wire [1:0] access_slot;

   // Slot codes for the three bank registers; zero means no bank register
   localparam SLOT_NONE     = 2'h0;
   localparam SLOT_CLK_ROLE = 2'h1;
   localparam SLOT_ADC_CH   = 2'h2;
   localparam SLOT_DAC_CH   = 2'h3;

   // Custom mask bit n enables channel n+1
   function [3:0] pick_mask;
      input [7:0] cfg;
      input [3:0] select_mask;
      begin
         if (cfg[`ACR_FORCE_CUSTOM_BIT])
            pick_mask = cfg[`ACR_CUSTOM_MASK_HI:`ACR_CUSTOM_MASK_LO];
         else
            pick_mask = select_mask;
      end
   endfunction

   assign bank_sel = (page_o == `ACR_BANK_PAGE);

   // ****************************************
   // Address decode
   // ****************************************
   // Shared by write and read so both always agree on what is mapped
   function [1:0] decode_slot;
      input [7:0] addr;
      input       sel;
      begin
         decode_slot = SLOT_NONE;
         if (sel)
         begin
            case (addr)
               `ACR_ADDR_CLK_ROLE: decode_slot = SLOT_CLK_ROLE;
               `ACR_ADDR_ADC_CH:   decode_slot = SLOT_ADC_CH;
               `ACR_ADDR_DAC_CH:   decode_slot = SLOT_DAC_CH;
               default:            decode_slot = SLOT_NONE;
            endcase
         end
      end
   endfunction

   assign access_slot = decode_slot(reg_addr_i, bank_sel);

   // ****************************************
   // Page select
   // ****************************************
   // Page register answers on every page so software can always move back
   always @(posedge clock_i)
   begin
      if (rst_i)
         page_o <= `ACR_RESET_VALUE;
      else if (reg_write_i && (reg_addr_i == `ACR_ADDR_PAGE))
         page_o <= reg_wdata_i;
   end

   // ****************************************
   // Register writes
   // ****************************************
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         serial_port_clock_role_cfg <= `ACR_RESET_VALUE;
         adc_dynamic_channel_cfg    <= `ACR_RESET_VALUE;
         dac_dynamic_channel_cfg    <= `ACR_RESET_VALUE;
      end
      else if (reg_write_i)
      begin
         // Reserved bits dropped on write, so stray ones never stick
         case (access_slot)
            SLOT_CLK_ROLE:
               serial_port_clock_role_cfg <= reg_wdata_i & `ACR_CLK_ROLE_WMASK;
            SLOT_ADC_CH:
               adc_dynamic_channel_cfg    <= reg_wdata_i & `ACR_CHAN_WMASK;
            SLOT_DAC_CH:
               dac_dynamic_channel_cfg    <= reg_wdata_i & `ACR_CHAN_WMASK;
            default:
               ;
         endcase
      end
   end

   // ****************************************
   // Read back
   // ****************************************
   always @*
   begin
      next_rdata = `ACR_RESET_VALUE;
      if (reg_addr_i == `ACR_ADDR_PAGE)
         next_rdata = page_o;
      else
      begin
         // Off-page and unmapped addresses read as zero
         case (access_slot)
            SLOT_CLK_ROLE: next_rdata = serial_port_clock_role_cfg;
            SLOT_ADC_CH:   next_rdata = adc_dynamic_channel_cfg;
            SLOT_DAC_CH:   next_rdata = dac_dynamic_channel_cfg;
            default:       next_rdata = `ACR_RESET_VALUE;
         endcase
      end
   end

   // ****************************************
   // Read data register
   // ****************************************
   // Held between reads so a slow host can pick it up late
   always @(posedge clock_i)
   begin
      if (rst_i)
         reg_rdata_o <= `ACR_RESET_VALUE;
      else if (reg_read_i)
         reg_rdata_o <= next_rdata;
   end

   // ****************************************
   // Dynamic channel selection
   // ****************************************
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         adc_channel_enable_o <= 4'h0;
         dac_channel_enable_o <= 4'h0;
      end
      else
      begin
         adc_channel_enable_o <= pick_mask(adc_dynamic_channel_cfg,
                                           adc_max_channel_select_i);
         dac_channel_enable_o <= pick_mask(dac_dynamic_channel_cfg,
                                           dac_max_channel_select_i);
      end
   end

   // ****************************************
   // Port role decoders
   // ****************************************
   acr_port_role u_primary_role
   (
      .clock_i          (clock_i),
      .rst_i            (rst_i),
      .override_i       (serial_port_clock_role_cfg[`ACR_PRI_OVERRIDE_BIT]),
      .role_select_i    (primary_role_select_i),
      .internal_fsync_i (serial_port_clock_role_cfg[`ACR_PRI_INT_FS_BIT]),
      .bclk_drive_o     (primary_bclk_drive_o),
      .fsync_drive_o    (primary_fsync_drive_o),
      .autodetect_en_o  (primary_autodetect_en_o),
      .fsync_internal_o (primary_fsync_internal_o)
   );

   acr_port_role u_secondary_role
   (
      .clock_i          (clock_i),
      .rst_i            (rst_i),
      .override_i       (serial_port_clock_role_cfg[`ACR_SEC_OVERRIDE_BIT]),
      .role_select_i    (secondary_role_select_i),
      .internal_fsync_i (serial_port_clock_role_cfg[`ACR_SEC_INT_FS_BIT]),
      .bclk_drive_o     (secondary_bclk_drive_o),
      .fsync_drive_o    (secondary_fsync_drive_o),
      .autodetect_en_o  (secondary_autodetect_en_o),
      .fsync_internal_o (secondary_fsync_internal_o)
   );

endmodule // acr_cfg_top

/* File: sim/acr_cfg_props.sv */
// Checker for the clock role and channel configuration bank.
// Assumes the register port and role selects are driven on clock_i.
`timescale 1ns/100ps
module acr_cfg_props
(
   input wire       clock_i,
   input wire       rst_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire       reg_write_i,
   input wire       reg_read_i,
   input wire [7:0] reg_rdata_o,
   input wire [7:0] page_o,
   input wire       primary_role_select_i,
   input wire       secondary_role_select_i,
   input wire       primary_bclk_drive_o,
   input wire       primary_fsync_drive_o,
   input wire       primary_autodetect_en_o,
   input wire       primary_fsync_internal_o,
   input wire       secondary_bclk_drive_o,
   input wire       secondary_fsync_drive_o,
   input wire       secondary_autodetect_en_o,
   input wire       secondary_fsync_internal_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   property p_pri_bclk;
      1'b1 |=> primary_bclk_drive_o == $past(primary_role_select_i);
   endproperty
   a_pri_bclk: assert property (p_pri_bclk)
      else $error("primary bit clock role wrong");
   property p_sec_bclk;
      1'b1 |=> secondary_bclk_drive_o == $past(secondary_role_select_i);
   endproperty
   a_sec_bclk: assert property (p_sec_bclk)
      else $error("secondary bit clock role wrong");
   // Split directions only exist while auto-detect is off
   property p_pri_ovr;
      primary_fsync_drive_o != primary_bclk_drive_o |-> !primary_autodetect_en_o;
   endproperty
   a_pri_ovr: assert property (p_pri_ovr)
      else $error("primary split role with autodetect");
   property p_sec_ovr;
      secondary_fsync_drive_o != secondary_bclk_drive_o |-> !secondary_autodetect_en_o;
   endproperty
   a_sec_ovr: assert property (p_sec_ovr)
      else $error("secondary split role with autodetect");
   property p_pri_int;
      primary_fsync_internal_o |-> primary_bclk_drive_o;
   endproperty
   a_pri_int: assert property (p_pri_int)
      else $error("primary internal sync outside controller");
   property p_sec_int;
      secondary_fsync_internal_o |-> secondary_bclk_drive_o;
   endproperty
   a_sec_int: assert property (p_sec_int)
      else $error("secondary internal sync outside controller");
   property p_page;
      reg_write_i && reg_addr_i == 8'h00 |=> page_o == $past(reg_wdata_i);
   endproperty
   a_page: assert property (p_page)
      else $error("page register not written");
   property p_unmapped;
      reg_read_i && reg_addr_i > 8'h0F |=> reg_rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_resv;
      reg_read_i && reg_addr_i == 8'h0D |=> (reg_rdata_o & 8'h39) == 8'h00;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved role bits not zero");
endmodule // acr_cfg_props

/* File: sim/acr_cfg_top_tb.sv */
// Self-checking bench for the clock role and channel configuration bank.
// Assumes acr_cfg_top and acr_cfg_props are compiled alongside.
`timescale 1ns/100ps
module acr_cfg_top_tb;
   reg        clock_i = 1'b0;
   reg        rst_i = 1'b1;
   reg  [7:0] addr = 8'h00, wdata = 8'h00, d, e;
   reg        wr_en = 1'b0, rd_en = 1'b0, psel = 1'b0, ssel = 1'b0;
   reg  [3:0] adc_sel = 4'h0, dac_sel = 4'h0, m;
   wire [7:0] rdata, page, roles;
   wire [3:0] adc_en, dac_en;
   integer    errors = 0, samples_checked = 0, i;
   acr_cfg_top dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_write_i(wr_en), .reg_read_i(rd_en), .reg_rdata_o(rdata), .page_o(page),
      .primary_role_select_i(psel), .secondary_role_select_i(ssel),
      .adc_max_channel_select_i(adc_sel), .dac_max_channel_select_i(dac_sel),
      .primary_bclk_drive_o(roles[7]), .primary_fsync_drive_o(roles[6]),
      .primary_autodetect_en_o(roles[5]), .primary_fsync_internal_o(roles[4]),
      .secondary_bclk_drive_o(roles[3]), .secondary_fsync_drive_o(roles[2]),
      .secondary_autodetect_en_o(roles[1]), .secondary_fsync_internal_o(roles[0]),
      .adc_channel_enable_o(adc_en), .dac_channel_enable_o(dac_en));
   initial forever #25 clock_i = ~clock_i;
   // Register bus results: read data and page
   task chk_reg(input [7:0] got, input [7:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("BAD t=%0t reg got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   // Derived outputs: port roles and channel enables
   task chk_out(input [7:0] got, input [7:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("BAD t=%0t out got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   // Strobe stands for exactly one taken edge
   task wr(input [7:0] a, input [7:0] v);
   begin
      @(posedge clock_i);
      addr  <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clock_i);
      wr_en <= 1'b0;
   end
   endtask
   // Read data is registered, so look one edge after the strobe is taken
   task rd(input [7:0] a);
   begin
      @(posedge clock_i);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clock_i);
      rd_en <= 1'b0;
      @(negedge clock_i);
      d = rdata;
   end
   endtask
   task settle;
   begin
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
   end
   endtask
   task t_reset;
   begin
      @(posedge clock_i);
      rst_i   <= 1'b1;
      psel    <= 1'b0;
      ssel    <= 1'b0;
      adc_sel <= 4'h0;
      dac_sel <= 4'h0;
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      settle;
      chk_out(roles, 8'h22);
      chk_out({adc_en, dac_en}, 8'h00);
      chk_reg(page, 8'h00);
      for (i = 13; i < 16; i = i + 1)
      begin
         rd(i[7:0]);
         chk_reg(d, 8'h00);
      end
   end
   endtask
   task t_roles;
   begin
      for (i = 0; i < 64; i = i + 1)
      begin
         @(posedge clock_i);
         psel <= i[2];
         ssel <= i[3];
         e = {i[0], i[1], 3'b000, i[4], i[5], 1'b0};
         wr(8'h0D, e);
         rd(8'h0D);
         chk_reg(d, e);
         e = {i[2], i[0] ^ i[2], ~i[0], i[2] & i[4], i[3], i[1] ^ i[3], ~i[1], i[3] & i[5]};
         chk_out(roles, e);
      end
   end
   endtask
   task t_chan;
   begin
      for (i = 0; i < 8; i = i + 1)
      begin
         m = 4'h1 << i[1:0];
         @(posedge clock_i);
         adc_sel <= ~m;
         dac_sel <= m ^ 4'h5;
         wr(8'h0E, {i[2], m, 3'b000});
         wr(8'h0F, {~i[2], m, 3'b000});
         settle;
         chk_out({adc_en, dac_en}, {i[2] ? m : ~m, i[2] ? m ^ 4'h5 : m});
         rd(8'h0E);
         chk_reg(d, {i[2], m, 3'b000});
         rd(8'h0F);
         chk_reg(d, {~i[2], m, 3'b000});
      end
   end
   endtask
   // Expects the ADC register left at 0xC0 by the last channel pass
   task t_page;
   begin
      wr(8'h0D, 8'h00);
      wr(8'h00, 8'h01);
      wr(8'h0D, 8'hC6);
      wr(8'h0E, 8'h00);
      rd(8'h0D);
      chk_reg(d, 8'h00);
      rd(8'h00);
      chk_reg(d, 8'h01);
      chk_reg(page, 8'h01);
      wr(8'h00, 8'h00);
      rd(8'h0D);
      chk_reg(d, 8'h00);
      rd(8'h0E);
      chk_reg(d, 8'hC0);
      // Deliberate ones in reserved bits to prove they never stick
      wr(8'h0D, 8'hFF);
      rd(8'h0D);
      chk_reg(d, 8'hC6);
      rd(8'h10);
      chk_reg(d, 8'h00);
      // Leave a non-zero page so the closing reset has something to clear
      wr(8'h00, 8'h02);
   end
   endtask
   task report_and_stop;
   begin
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   initial
   begin
      t_reset;
      t_roles;
      t_chan;
      t_page;
      t_reset;
      report_and_stop;
   end
   // Tests need about 500 cycles; 4000 cycles leaves ample margin
   initial
   begin
      #200000;
      errors = errors + 1;
      report_and_stop;
   end
endmodule // acr_cfg_top_tb
bind acr_cfg_top acr_cfg_props u_props (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i,
   .reg_write_i, .reg_read_i, .reg_rdata_o, .page_o, .primary_role_select_i,
   .secondary_role_select_i, .primary_bclk_drive_o, .primary_fsync_drive_o,
   .primary_autodetect_en_o, .primary_fsync_internal_o, .secondary_bclk_drive_o,
   .secondary_fsync_drive_o, .secondary_autodetect_en_o, .secondary_fsync_internal_o);
